/* tb/tcc_pin_model.sv */
/* tcc_pin_model: outside driver of the timer pins.
   assumes one-cycle requests from the bench, on core_clk. */
module tcc_pin_model (
   input  wire logic       core_clk,
   input  wire logic [2:0] pulseA,
   input  wire logic [2:0] pulseB,
   output logic      [2:0] lineA,
   output logic      [2:0] lineB,
   output logic      [2:0] extClk
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] a1Reg = '0, a2Reg = '0, b1Reg = '0, b2Reg = '0;
   // ==========================================
   // pulse stretch
   // a request becomes a three-cycle pulse, longer than one clock
   always_ff @(posedge core_clk) begin
      a1Reg <= pulseA;
      a2Reg <= a1Reg;
      b1Reg <= pulseB;
      b2Reg <= b1Reg;
   end
   assign lineA  = pulseA | a1Reg | a2Reg;
   assign lineB  = pulseB | b1Reg | b2Reg;
   assign extClk = lineB;  // shared clocks just follow line b
endmodule : tcc_pin_model

/* tb/tcc_timer_block_tb.sv */
/* tcc_timer_block_tb: register tests of the timer block.
   assumes the pin model drives every timer input. */
module tcc_timer_block_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tcc_pkg::*;
   logic        core_clk, reset, read, write, waitrequest;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, v, w;
   logic [2:0]  pA, pB, ioA, ioB, ext, irq, aOe, bOe;
   int          failures, checks;
   tcc_timer_block dut (.core_clk(core_clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .ioLineAIn(ioA), .ioLineAOut(), .ioLineAOe(aOe), .ioLineBIn(ioB), .ioLineBOut(),
      .ioLineBOe(bOe), .extClockIn(ext), .chanIrq(irq));
   tcc_pin_model pins (.core_clk(core_clk), .pulseA(pA), .pulseB(pB), .lineA(ioA),
      .lineB(ioB), .extClk(ext));
   // ==========================================
   // bus tasks
   // request held until waitrequest is sampled low; the caller releases it
   task automatic acc(input logic [7:0] a, input logic wr, input logic [31:0] d);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      v = readdata;
   endtask : acc
   task automatic pause(input int n);
      read <= 1'b0;
      write <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask : pause
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // ==========================================
   // clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      failures++;
      end_sim();
   end
   // ==========================================
   // tests
   initial begin
      {reset, read, write, address, writedata, pA, pB} = {1'b1, 48'h0};
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      acc(8'h1c, 1, 32'h8000);  // compare far away, keeps events quiet
      acc(8'h00, 1, 32'h4);
      acc(8'h20, 0, 0);
      chk("run off", 0, v[16]);
      acc(8'h00, 1, 32'h1);
      acc(8'h10, 0, 0);
      chk("idle", 0, v);
      acc(8'h00, 1, 32'h4);
      acc(8'h10, 0, 0);
      w = v;
      acc(8'h10, 0, 0);
      chk("count", w + 2, v);
      acc(8'h20, 0, 0);
      chk("run on", 1, v[16]);
      acc(8'h00, 1, 32'h3);
      acc(8'h10, 0, 0);
      w = v;
      acc(8'h10, 0, 0);
      chk("frozen", w, v);
      acc(8'h40, 1, 32'h1);
      acc(8'h80, 1, 32'h1);
      acc(8'hc0, 1, 32'h1);
      acc(8'h50, 0, 0);
      w = v;
      acc(8'h90, 0, 0);
      chk("sync", w + 2, v);
      acc(8'h3c, 0, 0);
      chk("unmapped", 0, v);
      acc(8'h24, 1, 32'hff);
      acc(8'h28, 1, 32'h01);
      acc(8'h28, 1, 32'h00);
      acc(8'h2c, 0, 0);
      chk("mask", 32'hfe, v);
      // a on rise, b on fall, b load switches the clock off
      acc(8'h04, 1, 32'h9002);
      acc(8'h00, 1, 32'h5);
      acc(8'h20, 0, 0);
      pause(1);
      pA <= 3'h1;
      @(posedge core_clk);
      pA <= 3'h0;
      pause(10);
      chk("irq", 1, irq[0]);
      acc(8'h20, 0, 0);
      chk("loads", 32'h60, v);
      acc(8'h14, 0, 0);
      w = v;
      acc(8'h18, 0, 0);
      chk("width", w + 3, v);
      acc(8'h84, 1, 32'h4);
      acc(8'h80, 1, 32'h2);
      acc(8'h80, 1, 32'h1);
      pause(1);
      pB <= 3'h4;
      @(posedge core_clk);
      pB <= 3'h0;
      pause(8);
      acc(8'ha0, 0, 0);
      chk("ext trig", 2'b11, {v[16], v[7]});
      acc(8'h90, 0, 0);
      chk("ext clear", 32'ha, v);
      acc(8'h44, 1, 32'h800);
      pause(2);
      chk("pin dir", 32'h10, {aOe, bOe});
      pause(1);
      end_sim();
   end
endmodule : tcc_timer_block_tb

/* verilog/tcc_pkg.sv */
/*
 * tcc_pkg: register map, field layout and event bit positions for the
 * three-channel timer counter block.
 * Assumes a 32-bit Avalon-MM slave and byte addresses, with one aligned word per register.
 */
package tcc_pkg;

   // ==========================================================
   // geometry
   localparam int          NUM_CH    = 3;
   localparam int          CNT_W     = 16;
   localparam int          ADDR_W    = 8;
   localparam logic [15:0] CNT_MAX   = 16'hffff;

   // ==========================================================
   // address map: channel n at n*0x40, block area at index 3
   localparam logic [1:0]  BLOCK_IDX = 2'h3;
   localparam logic [5:0]  OFF_CCR   = 6'h00;  // channel_control_reg, write only
   localparam logic [5:0]  OFF_CMR   = 6'h04;  // channel_mode_config
   localparam logic [5:0]  OFF_CV    = 6'h10;  // counter value, read only
   localparam logic [5:0]  OFF_CAPA  = 6'h14;  // capture_a_reg
   localparam logic [5:0]  OFF_CAPB  = 6'h18;  // capture_b_reg
   localparam logic [5:0]  OFF_CMPC  = 6'h1c;  // compare_c_reg
   localparam logic [5:0]  OFF_SR    = 6'h20;  // status, read clears events
   localparam logic [5:0]  OFF_IER   = 6'h24;  // irq enable, write only
   localparam logic [5:0]  OFF_IDR   = 6'h28;  // channel_irq_disable, write only
   localparam logic [5:0]  OFF_IMR   = 6'h2c;  // irq mask, read only
   localparam logic [5:0]  OFF_BCR   = 6'h00;  // block_control_reg in block area

   // ==========================================================
   // command bits
   localparam int          CCR_ON    = 0;      // clock_on_cmd
   localparam int          CCR_OFF   = 1;      // clock_off_cmd
   localparam int          CCR_TRIG  = 2;      // soft_trigger_bit
   localparam int          BCR_SYNC  = 0;
   localparam int          SR_RUN    = 16;     // clock_running_flag

   // event / status bit positions
   localparam int          EV_OVF    = 0;      // overflow_irq
   localparam int          EV_LOVR   = 1;      // load_overrun_irq
   localparam int          EV_AMATCH = 2;      // a_match_irq
   localparam int          EV_BMATCH = 3;      // b_match_irq
   localparam int          EV_CMATCH = 4;      // c_match_irq
   localparam int          EV_ALOAD  = 5;      // a_load_irq
   localparam int          EV_BLOAD  = 6;      // b_load_irq
   localparam int          EV_ETRG   = 7;      // ext_trigger_irq

   // edge select encodings, shared by trigger and load fields
   localparam logic [1:0]  EDGE_NONE = 2'h0;
   localparam logic [1:0]  EDGE_RISE = 2'h1;
   localparam logic [1:0]  EDGE_FALL = 2'h2;
   localparam logic [1:0]  EDGE_BOTH = 2'h3;

   // waveform external event source
   localparam logic [1:0]  SRC_IOB   = 2'h0;

   // ==========================================================
   // channel_mode_config layout, bit 15 down to bit 0
   typedef struct packed {
      logic [1:0] bLoadEdge;      // b_load_edge        15:14
      logic [1:0] aLoadEdge;      // a_load_edge        13:12
      logic       waveSel;        // waveform_select    11
      logic [1:0] evtSrc;         // io_b, ext clk 0..2 10:9
      logic       evtTrigEn;      // ext_event_trigger_en 8
      logic       offOnCMatch;    // clock_off_on_c_match 7
      logic       haltOnCMatch;   // halt_on_c_match    6
      logic       cMatchTrigEn;   // c_match_trigger_en 5
      logic       extTrigSrc;     // ext_trigger_source 4
      logic [1:0] extEdgeSel;     // ext_edge_select    3:2
      logic       offOnBCap;      // clock_off_on_b_capture 1
      logic       haltOnBCap;     // halt_on_b_capture  0
   } tcc_mode_t;

   localparam tcc_mode_t   MODE_RST  = '0;

endpackage : tcc_pkg

/* verilog/tcc_timer_block.sv */
/*
 * tcc_timer_block: three timer counter channels behind one Avalon-MM
 * slave, with clock gating, triggers, captures and per-event masks.
 * Assumes pin inputs already synchronous to core_clk, and a master
 * that holds each request until waitrequest is sampled low.
 */
// Our own choice: the Avalon-MM interface to the registers.
// Overview of operation
// - block holds three identical 16-bit up-counting channels
// - only clock_on_cmd re-enables the counter clock; clock_off_cmd disables it
// - capture mode: capture_b_reg load disables clock when that option set
// - waveform mode: compare_c_reg match disables clock when that option set
// - clock_running_flag in status reads set while the clock is enabled
// - any trigger kind starts the counter clock
// - b capture or waveform-mode c match halts the clock when halt options set
// - start and stop do nothing while the counter clock is disabled
// - waveform_select zero picks capture mode, one picks waveform mode
// - capture: both lines inputs; waveform: line a output, b unless it is the event source
// - every trigger clears the counter and starts the clock
// - writing soft_trigger_bit triggers the channel
// - block sync write triggers all channels in the same cycle
// - c match triggers only when c_match_trigger_en set
// - capture mode trigger input: line b when zero, line a when one
// - waveform event from line b or ext clocks, triggers if enabled
// - ext_edge_select: none, rising, falling, both edges
// - a_load_edge picks io_line_a edge loading capture_a_reg
// - b_load_edge picks io_line_a edge loading capture_b_reg
// - irq disable: one masks the event bit, zero has no effect
// - load events in capture mode only, a/b compare in waveform only
module tcc_timer_block (
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   // Avalon-MM slave
   input  wire logic [tcc_pkg::ADDR_W-1:0] address,
   input  wire logic                       read,
   input  wire logic                       write,
   input  wire logic [31:0]                writedata,
   output logic      [31:0]                readdata,
   output logic                            waitrequest,
   // timer pins, one per channel; external clocks shared
   input  wire logic [2:0]                 ioLineAIn,
   output logic      [2:0]                 ioLineAOut,
   output logic      [2:0]                 ioLineAOe,
   input  wire logic [2:0]                 ioLineBIn,
   output logic      [2:0]                 ioLineBOut,
   output logic      [2:0]                 ioLineBOe,
   input  wire logic [2:0]                 extClockIn,
   output logic      [2:0]                 chanIrq
);
   import tcc_pkg::*;

   // ==========================================================
   // helpers
   // edge detector used by trigger and both load selectors
   function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
      edgeHit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && !prev && cur) ||
                ((sel == EDGE_FALL || sel == EDGE_BOTH) && prev && !cur);
   endfunction : edgeHit

   // ==========================================================
   // state
   tcc_mode_t              mode_reg   [NUM_CH];
   logic [CNT_W-1:0]       cnt_reg    [NUM_CH];
   logic [CNT_W-1:0]       capA_reg   [NUM_CH];
   logic [CNT_W-1:0]       capB_reg   [NUM_CH];
   logic [CNT_W-1:0]       cmpC_reg   [NUM_CH];
   logic [7:0]             stat_reg   [NUM_CH];
   logic [7:0]             imr_reg    [NUM_CH];
   logic [NUM_CH-1:0]      clock_on_cmd_reg;
   logic [NUM_CH-1:0]      clkRun_reg;
   logic [NUM_CH-1:0]      aUnread_reg;
   logic [NUM_CH-1:0]      bUnread_reg;
   logic [2:0]             ioAPrev_reg;
   logic [2:0]             ioBPrev_reg;
   logic [2:0]             xcPrev_reg;
   logic [31:0]            rdMux;

   // per-channel combinational events
   logic [NUM_CH-1:0]      chSel, onCmd, offCmd, soft_trigger_bit, extTrig, trig;
   logic [NUM_CH-1:0]      aLoad, bLoad, cMatch, aMatch, bMatch, ovf;
   logic [NUM_CH-1:0]      stopEv, disEv, rdSr, rdA, rdB, wave;
   logic [7:0]             evt        [NUM_CH];

   // ==========================================================
   // bus decode: request taken on the edge where waitrequest is low
   logic                   acc, wrAcc, rdAcc, syncTrg;
   logic [1:0]             chIdx;
   logic [5:0]             off;

   assign acc     = (read || write) && !waitrequest;
   assign wrAcc   = acc && write;
   assign rdAcc   = acc && read;
   assign chIdx   = address[7:6];
   assign off     = {address[5:2], 2'h0};
   assign syncTrg = wrAcc && chIdx == BLOCK_IDX && off == OFF_BCR && writedata[BCR_SYNC];

   // one wait state on every access, then one cycle low
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // ==========================================================
   // per-channel event logic
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         logic extPin, extPrev;
         extPin    = 1'b0;
         extPrev   = 1'b0;
         wave[i]   = mode_reg[i].waveSel;
         chSel[i]  = chIdx == 2'(i);
         onCmd[i]  = wrAcc && chSel[i] && off == OFF_CCR && writedata[CCR_ON];
         offCmd[i] = wrAcc && chSel[i] && off == OFF_CCR && writedata[CCR_OFF];
         soft_trigger_bit[i]  = wrAcc && chSel[i] && off == OFF_CCR && writedata[CCR_TRIG];
         rdSr[i]   = rdAcc && chSel[i] && off == OFF_SR;
         rdA[i]    = rdAcc && chSel[i] && off == OFF_CAPA;
         rdB[i]    = rdAcc && chSel[i] && off == OFF_CAPB;
         // external trigger source
         if (!wave[i]) begin
            extPin  = mode_reg[i].extTrigSrc ? ioLineAIn[i] : ioLineBIn[i];
            extPrev = mode_reg[i].extTrigSrc ? ioAPrev_reg[i] : ioBPrev_reg[i];
         end else if (mode_reg[i].evtSrc == SRC_IOB) begin
            extPin  = ioLineBIn[i];
            extPrev = ioBPrev_reg[i];
         end else begin
            extPin  = extClockIn[mode_reg[i].evtSrc - 2'h1];
            extPrev = xcPrev_reg[mode_reg[i].evtSrc - 2'h1];
         end
         // a pulse shorter than one clock may fall between samples
         extTrig[i] = edgeHit(mode_reg[i].extEdgeSel, extPrev, extPin) &&
                      (!wave[i] || mode_reg[i].evtTrigEn);
         // capture loads, capture mode only
         aLoad[i]  = !wave[i] && edgeHit(mode_reg[i].aLoadEdge, ioAPrev_reg[i], ioLineAIn[i]);
         bLoad[i]  = !wave[i] && edgeHit(mode_reg[i].bLoadEdge, ioAPrev_reg[i], ioLineAIn[i]);
         // compares fire while the counter advances
         cMatch[i] = clock_on_cmd_reg[i] && clkRun_reg[i] && cnt_reg[i] == cmpC_reg[i];
         aMatch[i] = wave[i] && clock_on_cmd_reg[i] && clkRun_reg[i] && cnt_reg[i] == capA_reg[i];
         bMatch[i] = wave[i] && clock_on_cmd_reg[i] && clkRun_reg[i] && cnt_reg[i] == capB_reg[i];
         trig[i]   = soft_trigger_bit[i] || syncTrg || extTrig[i] ||
                     (cMatch[i] && mode_reg[i].cMatchTrigEn);
         stopEv[i] = (bLoad[i] && mode_reg[i].haltOnBCap) ||
                     (wave[i] && cMatch[i] && mode_reg[i].haltOnCMatch);
         disEv[i]  = offCmd[i] ||
                     (bLoad[i] && mode_reg[i].offOnBCap) ||
                     (wave[i] && cMatch[i] && mode_reg[i].offOnCMatch);
         ovf[i]    = clock_on_cmd_reg[i] && clkRun_reg[i] && !trig[i] && cnt_reg[i] == CNT_MAX;
         // event vector in status order
         evt[i]            = 8'h00;
         evt[i][EV_OVF]    = ovf[i];
         evt[i][EV_LOVR]   = (aLoad[i] && aUnread_reg[i]) || (bLoad[i] && bUnread_reg[i]);
         evt[i][EV_AMATCH] = aMatch[i];
         evt[i][EV_BMATCH] = bMatch[i];
         evt[i][EV_CMATCH] = cMatch[i];
         evt[i][EV_ALOAD]  = aLoad[i];
         evt[i][EV_BLOAD]  = bLoad[i];
         evt[i][EV_ETRG]   = extTrig[i];
      end
   end

   // ==========================================================
   // clock enable and start/stop
   // disable wins over clock_on_cmd in the same write
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         clock_on_cmd_reg  <= '0;
         clkRun_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (disEv[i]) begin
               clock_on_cmd_reg[i] <= 1'b0;
            end else if (onCmd[i]) begin
               clock_on_cmd_reg[i] <= 1'b1;
            end
            // start/stop only act while enabled
            if (clock_on_cmd_reg[i]) begin
               if (trig[i]) begin
                  clkRun_reg[i] <= 1'b1;
               end else if (stopEv[i]) begin
                  clkRun_reg[i] <= 1'b0;
               end
            end
         end
      end
   end

   // ==========================================================
   // counters, one per channel, counting core_clk
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (trig[i]) begin
               cnt_reg[i] <= '0;
            end else if (clock_on_cmd_reg[i] && clkRun_reg[i]) begin
               cnt_reg[i] <= cnt_reg[i] + 16'h0001;
            end
         end
      end
   end

   // ==========================================================
   // captures and compares; a and b are compares in waveform mode
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         aUnread_reg <= '0;
         bUnread_reg <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            capA_reg[i] <= '0;
            capB_reg[i] <= '0;
            cmpC_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (aLoad[i]) begin
               capA_reg[i]    <= cnt_reg[i];
               aUnread_reg[i] <= 1'b1;
            end else if (rdA[i]) begin
               aUnread_reg[i] <= 1'b0;
            end else if (wrAcc && chSel[i] && off == OFF_CAPA && wave[i]) begin
               capA_reg[i] <= writedata[CNT_W-1:0];
            end
            if (bLoad[i]) begin
               capB_reg[i]    <= cnt_reg[i];
               bUnread_reg[i] <= 1'b1;
            end else if (rdB[i]) begin
               bUnread_reg[i] <= 1'b0;
            end else if (wrAcc && chSel[i] && off == OFF_CAPB && wave[i]) begin
               capB_reg[i] <= writedata[CNT_W-1:0];
            end
            if (wrAcc && chSel[i] && off == OFF_CMPC) begin
               cmpC_reg[i] <= writedata[CNT_W-1:0];
            end
         end
      end
   end

   // ==========================================================
   // mode, status and mask registers
   // status: a new event in the clearing read cycle survives
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_CH; i++) begin
            mode_reg[i] <= MODE_RST;
            stat_reg[i] <= '0;
            imr_reg[i]  <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wrAcc && chSel[i] && off == OFF_CMR) begin
               mode_reg[i] <= tcc_mode_t'(writedata[15:0]);
            end
            stat_reg[i] <= (rdSr[i] ? 8'h00 : stat_reg[i]) | evt[i];
            if (wrAcc && chSel[i] && off == OFF_IER) begin
               imr_reg[i] <= imr_reg[i] | writedata[7:0];
            end else if (wrAcc && chSel[i] && off == OFF_IDR) begin
               imr_reg[i] <= imr_reg[i] & ~writedata[7:0];
            end
         end
      end
   end

   // ==========================================================
   // pin history for edge detection, and registered outputs
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ioAPrev_reg <= '0;
         ioBPrev_reg <= '0;
         xcPrev_reg  <= '0;
         ioLineAOut  <= '0;
         ioLineAOe   <= '0;
         ioLineBOut  <= '0;
         ioLineBOe   <= '0;
         chanIrq     <= '0;
      end else begin
         ioAPrev_reg <= ioLineAIn;
         ioBPrev_reg <= ioLineBIn;
         xcPrev_reg  <= extClockIn;
         for (int i = 0; i < NUM_CH; i++) begin
            // simple waveform: a/b set on their compare, cleared on c
            if (cMatch[i]) begin
               ioLineAOut[i] <= 1'b0;
               ioLineBOut[i] <= 1'b0;
            end else begin
               ioLineAOut[i] <= ioLineAOut[i] | aMatch[i];
               ioLineBOut[i] <= ioLineBOut[i] | bMatch[i];
            end
            ioLineAOe[i] <= wave[i];
            ioLineBOe[i] <= wave[i] && mode_reg[i].evtSrc != SRC_IOB;
            chanIrq[i]   <= |((stat_reg[i] | evt[i]) & imr_reg[i]);
         end
      end
   end

   // ==========================================================
   // read mux; data registered on the wait-state edge, one edge before the request is taken
   always_comb begin
      rdMux = 32'h0000_0000;
      for (int i = 0; i < NUM_CH; i++) begin
         if (chSel[i]) begin
            if (off == OFF_CMR) begin
               rdMux = {16'h0000, mode_reg[i]};
            end else if (off == OFF_CV) begin
               rdMux = {16'h0000, cnt_reg[i]};
            end else if (off == OFF_CAPA) begin
               rdMux = {16'h0000, capA_reg[i]};
            end else if (off == OFF_CAPB) begin
               rdMux = {16'h0000, capB_reg[i]};
            end else if (off == OFF_CMPC) begin
               rdMux = {16'h0000, cmpC_reg[i]};
            end else if (off == OFF_SR) begin
               rdMux = {15'h0000, clock_on_cmd_reg[i], 8'h00, stat_reg[i]};
            end else if (off == OFF_IMR) begin
               rdMux = {24'h000000, imr_reg[i]};
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         readdata <= '0;
      end else if (read && waitrequest) begin
         readdata <= rdMux;
      end
   end

   // ==========================================================
   // checks: bus handshake, then per channel
   a_bus_one_wait: assert property (@(posedge core_clk) disable iff (reset)
      (read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest not released after one wait state");

   for (genvar g = 0; g < NUM_CH; g++) begin : gChk
      a_sw_trig_start: assert property (@(posedge core_clk) disable iff (reset)
         soft_trigger_bit[g] && clock_on_cmd_reg[g] && !disEv[g] |=> clkRun_reg[g] && cnt_reg[g] == 16'h0000)
         else $error("soft trigger did not restart counter");
      a_off_cmd_stops: assert property (@(posedge core_clk) disable iff (reset)
         offCmd[g] |=> !clock_on_cmd_reg[g] ##1 (clock_on_cmd_reg[g] == $past(onCmd[g])))
         else $error("clock off command ignored");
      a_disabled_hold: assert property (@(posedge core_clk) disable iff (reset)
         !clock_on_cmd_reg[g] |=> $stable(clkRun_reg[g]))
         else $error("run state changed while disabled");
      a_b_capture_off: assert property (@(posedge core_clk) disable iff (reset)
         bLoad[g] && mode_reg[g].offOnBCap |=> !clock_on_cmd_reg[g])
         else $error("b capture did not disable clock");
      a_c_match_off: assert property (@(posedge core_clk) disable iff (reset)
         wave[g] && cMatch[g] && mode_reg[g].offOnCMatch |=> !clock_on_cmd_reg[g])
         else $error("c match did not disable clock");
      a_c_match_halt: assert property (@(posedge core_clk) disable iff (reset)
         wave[g] && cMatch[g] && mode_reg[g].haltOnCMatch && !trig[g] |=> !clkRun_reg[g])
         else $error("c match did not halt clock");
      a_load_copy: assert property (@(posedge core_clk) disable iff (reset)
         aLoad[g] |=> capA_reg[g] == $past(cnt_reg[g]))
         else $error("capture a holds wrong value");
      a_overflow_flag: assert property (@(posedge core_clk) disable iff (reset)
         ovf[g] |=> stat_reg[g][EV_OVF] && cnt_reg[g] == 16'h0000)
         else $error("overflow not flagged on wrap");
      a_mask_clear: assert property (@(posedge core_clk) disable iff (reset)
         wrAcc && chSel[g] && off == OFF_IDR && writedata[EV_CMATCH] |=> !imr_reg[g][EV_CMATCH])
         else $error("irq disable did not mask");
      a_sync_clears: assert property (@(posedge core_clk) disable iff (reset)
         syncTrg |=> cnt_reg[g] == 16'h0000)
         else $error("block sync did not clear counter");
   end

endmodule : tcc_timer_block
